// ---- srtr_params.svh ----
// constants for the set/reset/toggle relay
`ifndef SRTR_PARAMS_SVH
`define SRTR_PARAMS_SVH

// output value after reset or power-up without retention
`define SRTR_Q_RESET 1'b0
// value driven by set and by reset
`define SRTR_Q_SET   1'b1
`define SRTR_Q_CLEAR 1'b0

`endif

// ---- srtr_pkg.sv ----
// types for the set/reset/toggle relay
package srtr_pkg;

  // which kind of relay this instance is
  typedef enum logic {
    SRTR_LATCH,
    SRTR_TOGGLE
  } srtr_variant_t;

  // priority of a toggle relay when set and reset are both high; a latch always gives reset priority
  typedef enum logic {
    SRTR_CLEAR_DOMINANT,
    SRTR_SET_DOMINANT
  } srtr_prio_t;

  // one program cycle's worth of inputs
  typedef struct packed {
    logic set;
    logic clr;
    logic trg;
  } srtr_in_t;

  // fixed configuration
  typedef struct packed {
    srtr_variant_t variant;
    srtr_prio_t    prio;
    logic          retain;
  } srtr_cfg_t;

endpackage

// ---- srtr_relay.sv ----
// set/reset latch and toggle relay evaluated once per program cycle
`timescale 1ns/1ns
`default_nettype none
`include "srtr_params.svh"

module srtr_relay #(
  // configuration is a parameter so it cannot change while running
  parameter srtr_pkg::srtr_cfg_t CFG = '{srtr_pkg::SRTR_TOGGLE, srtr_pkg::SRTR_CLEAR_DOMINANT, 1'b0}
) (
  input  wire logic               core_clk_in,
  input  wire logic               srst_in,
  input  wire logic               cycle_in,
  input  wire srtr_pkg::srtr_in_t relay_in,
  input  wire logic               power_up_in,
  output logic                    q_out
);
  import srtr_pkg::*;

  // ********************************
  // configuration
  // ********************************
  // parameters only: nothing at run time can retune them
  localparam logic IS_TOGGLE = (CFG.variant == SRTR_TOGGLE);
  localparam logic SET_WINS  = IS_TOGGLE && (CFG.prio == SRTR_SET_DOMINANT);
  localparam logic RETAIN    = CFG.retain;

  // ********************************
  // state
  // ********************************
  // q_q is the relay itself, trg_prev_q the trigger at the last taken
  // cycle, retained_q the copy that outlives a power failure
  logic q_q;
  logic q_d;
  logic trg_prev_q;
  logic trg_prev_d;
  logic retained_q;
  logic retained_d;

  // ********************************
  // next-state decode
  // ********************************
  wire logic s         = relay_in.set;
  wire logic r         = relay_in.clr;
  wire logic t         = relay_in.trg;
  // a program cycle is evaluated only when no power-up is pending
  wire logic run_cyc   = cycle_in & ~power_up_in;
  // edge is found against last program cycle's sample, not the clock,
  // so a stalled program never sees a false edge
  wire logic trg_rise  = t & ~trg_prev_q;
  wire logic do_toggle = IS_TOGGLE & trg_rise & ~s & ~r;
  // latch is the toggle with no edge and clear priority
  wire logic both_val  = SET_WINS ? `SRTR_Q_SET : `SRTR_Q_CLEAR;
  wire logic resume    = RETAIN ? retained_q : `SRTR_Q_RESET;
  // what one program cycle gives: both, set, reset, toggle, hold
  wire logic eval_val  = (s & r)   ? both_val :
                         s         ? `SRTR_Q_SET :
                         r         ? `SRTR_Q_CLEAR :
                         do_toggle ? ~q_q :
                                     q_q;

  // power-up wins over a program cycle; any other edge holds, which
  // keeps every flip-flop free of a clock enable
  assign q_d = power_up_in ? resume :
               cycle_in    ? eval_val :
                             q_q;

  // power-up forgets the trigger: the first cycle after it takes a trigger
  // that is already high as a low to high change, so it can toggle
  assign trg_prev_d = power_up_in ? 1'b0 :
                      cycle_in    ? t :
                                    trg_prev_q;

  // the copy follows each evaluated cycle; with retention reset leaves
  // it alone, without retention reset clears it
  assign retained_d = (srst_in && !RETAIN)  ? `SRTR_Q_RESET :
                      (run_cyc && !srst_in) ? q_d :
                                              retained_q;

  // ********************************
  // registers
  // ********************************
  // relay state and trigger history
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      q_q        <= `SRTR_Q_RESET;
      trg_prev_q <= 1'b0;
    end else begin
      q_q        <= q_d;
      trg_prev_q <= trg_prev_d;
    end
  end

  // limitation: with retention the copy has no reset, so a power-up
  // before the first program cycle restores an unknown value
  always_ff @(posedge core_clk_in) begin
    retained_q <= retained_d;
  end

  // output straight from the flip-flop
  assign q_out = q_q;

  // ********************************
  // checks
  // ********************************
  chk_set_alone: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && relay_in.set && !relay_in.clr) |=> q_out)
    else $error("set alone did not raise output");

  chk_clr_alone: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && !relay_in.set && relay_in.clr) |=> !q_out)
    else $error("reset alone did not lower output");

  chk_both_high: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && relay_in.set && relay_in.clr) |=> (q_out == SET_WINS))
    else $error("set and reset resolved wrongly");

  chk_toggle_edge: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && do_toggle) |=> (q_out != $past(q_out)))
    else $error("trigger edge did not invert output");

  chk_hold_idle: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && !relay_in.set && !relay_in.clr && !trg_rise) |=> $stable(q_out))
    else $error("output changed with no cause");

  chk_no_cycle: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!cycle_in && !power_up_in) |=> $stable(q_out))
    else $error("output changed outside a program cycle");

  chk_power_up: assert property (@(posedge core_clk_in) disable iff (srst_in)
    power_up_in |=> (q_out == (RETAIN ? $past(retained_q) : 1'b0)))
    else $error("power-up value wrong");

  chk_trg_blocked: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in && !power_up_in && (relay_in.set || relay_in.clr)) |=> (trg_prev_q == $past(relay_in.trg)))
    else $error("trigger history lost during set or reset");

  // ********************************
  // latch checks
  // ********************************
  // these only bite in a latch build; in a toggle build they are vacuous
  // set alone in a latch build raises the output
  chk_latch_set: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!IS_TOGGLE && run_cyc
     && relay_in.set && !relay_in.clr) |=>
    q_out)
    else $error("latch set alone did not raise output");

  // reset alone in a latch build lowers the output
  chk_latch_clr: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!IS_TOGGLE && run_cyc
     && !relay_in.set && relay_in.clr) |=>
    !q_out)
    else $error("latch reset alone did not lower output");

  // reset beats set in a latch build
  chk_latch_both: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!IS_TOGGLE && run_cyc
     && relay_in.set && relay_in.clr) |=>
    !q_out)
    else $error("latch did not give reset priority");

  // a latch never looks at the trigger
  chk_latch_no_trg: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!IS_TOGGLE && run_cyc
     && !relay_in.set && !relay_in.clr) |=>
    $stable(q_out))
    else $error("latch output moved with set and reset low");

  // power return restores the stored copy in a retaining latch
  chk_latch_retain: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!IS_TOGGLE && RETAIN
     && power_up_in) |=>
    (q_out == $past(retained_q)))
    else $error("latch did not restore retained state");

  // ********************************
  // toggle checks
  // ********************************
  // these only bite in a toggle build; in a latch build they are vacuous
  // a forgetful toggle relay starts low after power return
  chk_tog_forget: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && !RETAIN
     && power_up_in) |=>
    !q_out)
    else $error("toggle relay kept state without retention");

  // trigger low and clear priority behaves as the latch table
  chk_tog_equiv: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && !SET_WINS && run_cyc
     && !relay_in.trg) |=>
    (q_out == ($past(relay_in.clr) ? 1'b0 : $past(relay_in.set) ? 1'b1 : $past(q_out))))
    else $error("toggle relay differs from latch with trigger low");

  // a trigger edge under set does not invert
  chk_set_trg: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && run_cyc && trg_rise
     && relay_in.set && !relay_in.clr) |=>
    q_out)
    else $error("trigger acted while set was high");

  // a trigger edge under reset does not invert
  chk_clr_trg: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && run_cyc && trg_rise
     && !relay_in.set && relay_in.clr) |=>
    !q_out)
    else $error("trigger acted while reset was high");

  // set priority gives high when both are high
  chk_sd_both: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (SET_WINS && run_cyc
     && relay_in.set && relay_in.clr) |=>
    q_out)
    else $error("set priority did not give high");

  // clear priority gives low when both are high
  chk_cd_both: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && !SET_WINS && run_cyc
     && relay_in.set && relay_in.clr) |=>
    !q_out)
    else $error("clear priority did not give low");

  // a trigger held high is no edge and leaves the output alone
  chk_tog_held: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (IS_TOGGLE && run_cyc && relay_in.trg && trg_prev_q
     && !relay_in.set && !relay_in.clr) |=>
    $stable(q_out))
    else $error("held trigger inverted the output");

  // ********************************
  // trigger history checks
  // ********************************
  // history is what makes a held trigger harmless, so guard it closely
  // each evaluated cycle records its trigger
  chk_hist_follow: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cycle_in
     && !power_up_in) |=>
    (trg_prev_q == $past(relay_in.trg)))
    else $error("trigger history missed a program cycle");

  // a stalled edge leaves the history alone
  chk_hist_stall: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!cycle_in
     && !power_up_in) |=>
    $stable(trg_prev_q))
    else $error("trigger history moved outside a program cycle");

  // power return clears the history
  chk_hist_pu: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (power_up_in
     && !srst_in) |=>
    !trg_prev_q)
    else $error("trigger history kept across power-up");

  // ********************************
  // retention and reset checks
  // ********************************
  // the copy must track the output or a restore brings back stale state
  // each evaluated cycle leaves the copy equal to the output
  chk_copy_follow: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (RETAIN && cycle_in
     && !power_up_in) |=>
    (retained_q == q_out))
    else $error("retained copy lags the output");

  // a power-up only reads the copy
  chk_copy_pu: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (RETAIN
     && power_up_in) |=>
    $stable(retained_q))
    else $error("power-up overwrote the retained copy");

  // a stalled edge leaves the copy alone
  chk_copy_stall: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!cycle_in
     && !power_up_in) |=>
    $stable(retained_q))
    else $error("retained copy moved outside a program cycle");

  // any build without retention comes back low
  chk_no_retain_pu: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!RETAIN
     && power_up_in) |=>
    !q_out)
    else $error("output not cleared at power-up without retention");

  // reset clears the output and the trigger history
  chk_reset_low: assert property (@(posedge core_clk_in)
    srst_in |=>
    (!q_out
     && !trg_prev_q))
    else $error("reset did not clear the relay");

endmodule

`default_nettype wire

// ---- srtr_src.sv ----
// upstream program blocks that feed the relay
`timescale 1ns/1ns
`default_nettype none
module srtr_src (
  input  wire logic       hold_in,
  input  wire logic [2:0] bits_in,
  output srtr_pkg::srtr_in_t relay_out,
  output logic            cycle_out
);
  import srtr_pkg::*;
  // a stalled program evaluates nothing at this edge
  assign cycle_out = ~hold_in;
  assign relay_out = srtr_in_t'(bits_in);
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for latch and toggle relay
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import srtr_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       srst_in     = 1'b1;
  logic       pu          = 1'b0;
  logic       hold        = 1'b0;
  logic [2:0] bits        = 3'h0;
  logic       cyc;
  srtr_in_t   rin;
  logic       q_l;
  logic       q_t;
  logic       q_c;
  int         fails       = 0;
  int         compares    = 0;
  always #4 core_clk_in = ~core_clk_in;
  srtr_src src (.hold_in(hold), .bits_in(bits), .relay_out(rin), .cycle_out(cyc));
  // latch keeps its state, toggle is set dominant and forgets
  srtr_relay #(.CFG('{SRTR_LATCH, SRTR_CLEAR_DOMINANT, 1'b1})) dut (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .cycle_in(cyc), .relay_in(rin), .power_up_in(pu), .q_out(q_l));
  srtr_relay #(.CFG('{SRTR_TOGGLE, SRTR_SET_DOMINANT, 1'b0})) dut_tog (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .cycle_in(cyc), .relay_in(rin), .power_up_in(pu), .q_out(q_t));
  // clear dominant toggle must match the latch while the trigger stays low
  srtr_relay #(.CFG('{SRTR_TOGGLE, SRTR_CLEAR_DOMINANT, 1'b1})) dut_cd (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .cycle_in(cyc), .relay_in(rin), .power_up_in(pu), .q_out(q_c));
  // ****************
  // checking helpers
  // ****************
  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs as {set, clr, trg}; one edge, then both outputs
  task automatic step(input logic [2:0] b, input logic el, input logic et);
    bits = b;
    @(posedge core_clk_in);
    #1;
    chk(q_l, el);
    chk(q_t, et);
  endtask
  // as step, and the clear dominant toggle must follow the latch
  task automatic step_c(input logic [2:0] b, input logic el, input logic et);
    step(b, el, et);
    chk(q_c, el);
  endtask
  task automatic finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_set_clr;
    step_c(3'h4, 1'b1, 1'b1);
    step_c(3'h0, 1'b1, 1'b1);
    step_c(3'h6, 1'b0, 1'b1);
    step_c(3'h2, 1'b0, 1'b0);
  endtask
  // a held trigger must not toggle twice
  task automatic t_toggle;
    step(3'h1, 1'b0, 1'b1);
    step(3'h1, 1'b0, 1'b1);
    step(3'h0, 1'b0, 1'b1);
    step(3'h1, 1'b0, 1'b0);
    step(3'h0, 1'b0, 1'b0);
    step(3'h3, 1'b0, 1'b0);
  endtask
  // skipped cycle, then power return with and without retention
  task automatic t_power;
    hold = 1'b1;
    step(3'h4, 1'b0, 1'b0);
    hold = 1'b0;
    step(3'h4, 1'b1, 1'b1);
    pu = 1'b1;
    step(3'h0, 1'b1, 1'b0);
    pu = 1'b0;
    // power failure mid-run: reset clears, power return restores
    srst_in = 1'b1;
    step(3'h0, 1'b0, 1'b0);
    srst_in = 1'b0;
    pu = 1'b1;
    step(3'h0, 1'b1, 1'b0);
    pu = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1;
    srst_in = 1'b0;
    t_set_clr();
    t_toggle();
    t_power();
    finish_test();
  end
  // cut a hang short well past the expected run
  initial begin
    #2000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
